// File: src/twg_gen.sv
// tape write test pattern generator: sequencer, fifo, strobe stage
// assumes an async, active-low write forward gate pin and a register master
`timescale 1ns/1ps
`default_nettype none

module twg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic full;
    logic empty;

    assign empty = (wp_r == rp_r);
    assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rp_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
        end else if (flush) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (in_valid && !full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (out_ready && !empty) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule : twg_fifo

module twg_gen #(
    parameter int BLOCK_DELAY = twg_pkg::BLOCK_DELAY_CYC,
    parameter int PERIOD_MAX = twg_pkg::LOW_MAX_CYC,
    parameter int PERIOD_SPLIT = twg_pkg::SPLIT_CYC,
    parameter int PERIOD_MIN = twg_pkg::HIGH_MIN_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic write_forward_gate_b,
    output logic write_track_zero,
    output logic write_track_one,
    output logic [5:0] write_tracks_hi,
    output logic write_parity_track,
    output logic write_strobe,
    output logic write_reset_pulse
);
    import twg_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [3:0] ctrl_r;
    logic [16:0] period_r;
    logic [7:0] pat_r [CHARS];
    logic burst;
    logic odd;
    logic seven;
    logic sel_pat;
    logic [3:0] pat_idx;

    assign burst = ctrl_r[CTRL_BURST];
    assign odd = ctrl_r[CTRL_ODD];
    assign seven = ctrl_r[CTRL_SEVEN];
    assign pat_idx = 4'((reg_addr - REG_PAT0) >> 2);
    // compare the full offset so addresses past the table do not alias
    assign sel_pat = (reg_addr >= REG_PAT0) && (reg_addr[1:0] == 2'b00)
        && (((reg_addr - REG_PAT0) >> 2) <= 8'(LAST_CHAR));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= CTRL_RESET;
            period_r <= PERIOD_RESET;
            for (int i = 0; i < CHARS; i++) begin
                pat_r[i] <= 8'h00;
            end
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                ctrl_r <= reg_wdata[3:0];
            end
            if (reg_addr == REG_PERIOD) begin
                period_r <= reg_wdata[16:0];
            end
            if (sel_pat) begin
                pat_r[pat_idx] <= reg_wdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // gate synchroniser and master clock
    // ------------------------------------------------------------------
    logic gate_s1_r;
    logic gate_s2_r;
    logic gate_act;
    logic [16:0] lo_lim;
    logic [16:0] hi_lim;
    logic [16:0] period_eff;
    logic [16:0] div_r;
    logic tick_r;

    assign gate_act = !gate_s2_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_s1_r <= 1'b1;
            gate_s2_r <= 1'b1;
        end else begin
            gate_s1_r <= write_forward_gate_b;
            gate_s2_r <= gate_s1_r;
        end
    end

    // range jumper: clamp software's period into the selected band
    always_comb begin
        lo_lim = ctrl_r[CTRL_HIGH] ? 17'(PERIOD_MIN) : 17'(PERIOD_SPLIT);
        hi_lim = ctrl_r[CTRL_HIGH] ? 17'(PERIOD_SPLIT) : 17'(PERIOD_MAX);
        if (period_r < lo_lim) begin
            period_eff = lo_lim;
        end else if (period_r > hi_lim) begin
            period_eff = hi_lim;
        end else begin
            period_eff = period_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else if (div_r >= period_eff - 17'h00001) begin
            div_r <= '0;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 17'h00001;
            tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // burst control
    // ------------------------------------------------------------------
    twg_state_t state_r;
    logic [23:0] dly_r;
    logic [2:0] tail_r;
    logic writing;

    // continuous mode bypasses the gate entirely
    assign writing = !burst || (state_r == TWG_WRITE);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= TWG_IDLE;
            dly_r <= '0;
            tail_r <= '0;
        end else if (!burst) begin
            state_r <= TWG_IDLE;
        end else begin
            unique case (state_r)
                TWG_IDLE: begin
                    dly_r <= '0;
                    if (gate_act) begin
                        state_r <= TWG_SETTLE;
                    end
                end
                TWG_SETTLE: begin
                    dly_r <= dly_r + 24'h000001;
                    tail_r <= '0;
                    if (!gate_act) begin
                        state_r <= TWG_TAIL;
                    end else if (dly_r == 24'(BLOCK_DELAY - 1)) begin
                        state_r <= TWG_WRITE;
                    end
                end
                TWG_WRITE: begin
                    tail_r <= '0;
                    if (!gate_act) begin
                        state_r <= TWG_TAIL;
                    end
                end
                TWG_TAIL: begin
                    if (tick_r) begin
                        tail_r <= tail_r + 3'h1;
                        if (tail_r == TAIL_LAST) begin
                            state_r <= TWG_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // write reset pulse
    // ------------------------------------------------------------------
    logic [8:0] wrs_cnt_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_reset_pulse <= 1'b0;
            wrs_cnt_r <= '0;
        end else if (!burst) begin
            write_reset_pulse <= 1'b0;
            wrs_cnt_r <= '0;
        end else if (state_r == TWG_TAIL && tick_r && tail_r == TAIL_LAST) begin
            write_reset_pulse <= 1'b1;
            wrs_cnt_r <= '0;
        end else if (write_reset_pulse) begin
            wrs_cnt_r <= wrs_cnt_r + 9'h001;
            if (wrs_cnt_r == STB_WID_LAST) begin
                write_reset_pulse <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // character sequencer feeding the fifo
    // ------------------------------------------------------------------
    logic [3:0] seq_r;
    logic [3:0] seq_nxt;
    logic push;
    logic in_ready;
    logic [7:0] fifo_out;
    logic out_valid;
    logic pop;

    assign seq_nxt = (seq_r == LAST_CHAR) ? 4'h0 : seq_r + 4'h1;
    // a full fifo holds the sequencer rather than dropping a character
    assign push = tick_r && writing && in_ready;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seq_r <= LAST_CHAR;
        end else if (!writing) begin
            seq_r <= LAST_CHAR;
        end else if (push) begin
            seq_r <= seq_nxt;
        end
    end

    twg_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .flush(!writing),
        .in_data(pat_r[seq_nxt]),
        .in_valid(push),
        .in_ready(in_ready),
        .out_data(fifo_out),
        .out_valid(out_valid),
        .out_ready(pop)
    );

    // ------------------------------------------------------------------
    // output stage: present data, wait, then strobe
    // ------------------------------------------------------------------
    logic [7:0] hold_r;
    logic [7:0] masked;
    logic [8:0] stb_cnt_r;
    logic busy_r;

    assign pop = out_valid && writing && !busy_r;
    assign masked = {hold_r[7:2], seven ? 2'b00 : hold_r[1:0]};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_r <= 8'h00;
            busy_r <= 1'b0;
            stb_cnt_r <= '0;
            write_strobe <= 1'b0;
        end else if (!writing) begin
            hold_r <= 8'h00;
            busy_r <= 1'b0;
            stb_cnt_r <= '0;
            write_strobe <= 1'b0;
        end else if (pop) begin
            hold_r <= fifo_out;
            busy_r <= 1'b1;
            stb_cnt_r <= '0;
        end else if (busy_r && !write_strobe) begin
            stb_cnt_r <= stb_cnt_r + 9'h001;
            if (stb_cnt_r == STB_DLY_LAST) begin
                write_strobe <= 1'b1;
                stb_cnt_r <= '0;
            end
        end else if (write_strobe) begin
            stb_cnt_r <= stb_cnt_r + 9'h001;
            if (stb_cnt_r == STB_WID_LAST) begin
                write_strobe <= 1'b0;
                busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_track_zero <= 1'b0;
            write_track_one <= 1'b0;
            write_tracks_hi <= 6'h00;
            write_parity_track <= 1'b0;
        end else begin
            write_track_zero <= masked[0];
            write_track_one <= masked[1];
            write_tracks_hi <= masked[7:2];
            write_parity_track <= (^masked) ^ odd;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                reg_rdata <= {28'h0000000, ctrl_r};
            end else if (reg_addr == REG_PERIOD) begin
                reg_rdata <= {15'h0000, period_r};
            end else if (reg_addr == REG_STATUS) begin
                reg_rdata <= {22'h000000, !in_ready, !out_valid, writing,
                    state_r, gate_act, seq_r};
            end else if (sel_pat) begin
                reg_rdata <= {24'h000000, pat_r[pat_idx]};
            end else begin
                reg_rdata <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_seq_wrap;
        @(posedge clk) disable iff (!rst_b)
        (push && seq_r == LAST_CHAR) |=> (seq_r == 4'h0);
    endproperty
    a_seq_wrap: assert property (p_seq_wrap)
        else $error("sequencer did not wrap after nine");

    property p_strobe_delay;
        @(posedge clk) disable iff (!rst_b)
        (pop && !burst) |-> ##80 !write_strobe ##1 write_strobe;
    endproperty
    a_strobe_delay: assert property (p_strobe_delay)
        else $error("strobe not 400 ns after character");

    property p_strobe_width;
        @(posedge clk) disable iff (!rst_b)
        ($rose(write_strobe) && !burst)
            |-> ##[399:399] write_strobe ##1 !write_strobe;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe width not 2 us");

    property p_block_delay;
        @(posedge clk) disable iff (!rst_b)
        (burst && state_r == TWG_IDLE && gate_act) |=> !writing [*8];
    endproperty
    a_block_delay: assert property (p_block_delay)
        else $error("writing began without settle delay");

    property p_no_wrs_cont;
        @(posedge clk) disable iff (!rst_b)
        (!burst && !$past(burst)) |-> !write_reset_pulse;
    endproperty
    a_no_wrs_cont: assert property (p_no_wrs_cont)
        else $error("write reset in continuous mode");

    property p_seven_track;
        @(posedge clk) disable iff (!rst_b)
        $past(seven) |-> (!write_track_zero && !write_track_one);
    endproperty
    a_seven_track: assert property (p_seven_track)
        else $error("tracks zero or one driven in seven-track");

    property p_parity;
        @(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> ((^{write_tracks_hi, write_track_one,
            write_track_zero, write_parity_track}) == $past(odd));
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity track wrong");

    property p_wrs_after_tail;
        @(posedge clk) disable iff (!rst_b)
        $rose(write_reset_pulse) |-> (tail_r == TAIL_DONE);
    endproperty
    a_wrs_after_tail: assert property (p_wrs_after_tail)
        else $error("write reset not on fourth tick");

    property p_stop_on_gate;
        @(posedge clk) disable iff (!rst_b)
        (burst && !gate_act) |=> ##1 (!write_strobe && hold_r == 8'h00);
    endproperty
    a_stop_on_gate: assert property (p_stop_on_gate)
        else $error("writing continued after gate ended");
endmodule : twg_gen

`default_nettype wire

// File: inc/twg_pkg.sv
// constants for the tape write test pattern generator
// assumes a 200 MHz system clock; all counts derive from it
package twg_pkg;
    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_PS = 5000;
    localparam int LOW_MIN_HZ = 2000;
    localparam int RANGE_SPLIT_HZ = 16000;
    localparam int HIGH_MAX_HZ = 36000;
    localparam int BLOCK_DELAY_MS = 50;
    localparam int STB_DELAY_NS = 400;
    localparam int STB_WIDTH_NS = 2000;
    localparam int TAIL_TICKS = 4;
    localparam int CHARS = 10;
    // longest master period (slowest rate) rounds down, shortest rounds up
    localparam int LOW_MAX_CYC = CLK_HZ / LOW_MIN_HZ;
    localparam int SPLIT_CYC = CLK_HZ / RANGE_SPLIT_HZ;
    localparam int HIGH_MIN_CYC = (CLK_HZ + HIGH_MAX_HZ - 1) / HIGH_MAX_HZ;
    localparam int BLOCK_DELAY_CYC = BLOCK_DELAY_MS * (CLK_HZ / 1000);
    localparam int STB_DLY_CYC = (STB_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int STB_WID_CYC = (STB_WIDTH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam logic [8:0] STB_DLY_LAST = 9'(STB_DLY_CYC - 1);
    localparam logic [8:0] STB_WID_LAST = 9'(STB_WID_CYC - 1);
    localparam logic [3:0] LAST_CHAR = 4'(CHARS - 1);
    localparam logic [2:0] TAIL_LAST = 3'(TAIL_TICKS - 1);
    localparam logic [2:0] TAIL_DONE = 3'(TAIL_TICKS);
    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PERIOD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PAT0 = 8'h10;
    localparam int CTRL_BURST = 0;
    localparam int CTRL_ODD = 1;
    localparam int CTRL_SEVEN = 2;
    localparam int CTRL_HIGH = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [16:0] PERIOD_RESET = 17'h030D4;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 8;
    typedef enum logic [1:0] {
        TWG_IDLE = 2'b00,
        TWG_SETTLE = 2'b01,
        TWG_WRITE = 2'b10,
        TWG_TAIL = 2'b11
    } twg_state_t;
endpackage : twg_pkg

// File: tb/twg_partner.sv
// far side of the generator: control tester gating bursts, tape unit capture
// assumes clk is the generator's clock, used here only for timekeeping
`timescale 1ns/1ps
`default_nettype none

module twg_partner #(
    parameter int MOTION_DLY = 100,
    parameter int DISPLAY_LEN = 500
) (
    input wire logic clk,
    input wire logic [7:0] tracks,
    input wire logic parity,
    input wire logic strobe,
    input wire logic reset_pulse,
    output logic gate_b,
    output logic motion_cmd
);
    // ------------------------------------------------------------------
    // tape unit capture log
    // ------------------------------------------------------------------
    int cyc = 0;
    int stb_rise_t = 0;
    int stb_interval = 0;
    int stb_width = 0;
    int stb_cnt = 0;
    int first_t = 0;
    int rst_cnt = 0;
    int rst_rise_t = 0;
    int rst_width = 0;
    int gate_fall_t = 0;
    int gate_rise_t = 0;
    int unstable = 0;
    int lrc_t = 0;
    logic [8:0] cap [$];
    logic [8:0] lrc = 9'h000;
    logic [8:0] held = 9'h000;
    logic stb_q = 1'b0;
    logic rst_q = 1'b0;
    logic gate_q = 1'b1;

    initial begin
        gate_b = 1'b1;
        motion_cmd = 1'b0;
    end

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (strobe && !stb_q) begin
            stb_interval = cyc - stb_rise_t;
            stb_rise_t = cyc;
            stb_cnt++;
            if (stb_cnt == 1) begin
                first_t = cyc;
            end
            held = {parity, tracks};
            cap.push_back(held);
        end
        if (strobe && stb_q && {parity, tracks} !== held) begin
            unstable++;
        end
        if (!strobe && stb_q) begin
            stb_width = cyc - stb_rise_t;
        end
        if (reset_pulse && !rst_q) begin
            rst_cnt++;
            rst_rise_t = cyc;
            // nine-track unit: check char eight write periods after gate
            lrc_t = gate_rise_t + 8 * stb_interval;
            // check char leaves every track with an even count
            lrc = 9'h000;
            foreach (cap[i]) begin
                lrc ^= cap[i];
            end
        end
        if (!reset_pulse && rst_q) begin
            rst_width = cyc - rst_rise_t;
        end
        if (!gate_b && gate_q) begin
            gate_fall_t = cyc;
        end
        if (gate_b && !gate_q) begin
            gate_rise_t = cyc;
        end
        stb_q = strobe;
        rst_q = reset_pulse;
        gate_q = gate_b;
    end

    // ------------------------------------------------------------------
    // control tester sequence
    // ------------------------------------------------------------------
    task automatic clear_log();
        cap.delete();
        stb_cnt = 0;
        rst_cnt = 0;
        unstable = 0;
    endtask : clear_log

    task automatic block_cycle(input int len, input int tail, output int cnt);
        motion_cmd <= 1'b1;
        repeat (MOTION_DLY) @(posedge clk);
        gate_b <= 1'b0;
        repeat (len) @(posedge clk);
        gate_b <= 1'b1;
        // gate sync delay plus a strobe launched before writing drops
        repeat (5) @(posedge clk);
        cnt = stb_cnt;
        repeat (tail) @(posedge clk);
        // display period: motion off, gate held off for DISPLAY_LEN cycles
        motion_cmd <= 1'b0;
        repeat (DISPLAY_LEN) @(posedge clk);
    endtask : block_cycle
endmodule : twg_partner

`default_nettype wire

// File: tb/twg_gen_bench.sv
// self-checking bench for the tape write test pattern generator
// assumes the generator with shortened counts and the far-side model
`timescale 1ns/1ps
`default_nettype none

module twg_gen_bench;
    import twg_pkg::*;
    // shortened counts; strobe must fit inside one master period
    localparam int BDLY = 200;
    localparam int PMAX = 4000;
    localparam int PSPLIT = 2000;
    localparam int PMIN = 1000;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic write_forward_gate_b;
    logic write_track_zero;
    logic write_track_one;
    logic [5:0] write_tracks_hi;
    logic write_parity_track;
    logic write_strobe;
    logic write_reset_pulse;
    logic motion_cmd;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int end_cnt;
    logic [7:0] pat [10];
    logic [31:0] rd;
    logic [8:0] exp_lrc;
    logic [8:0] exp_char;

    always #2.5 clk = ~clk;

    twg_gen #(.BLOCK_DELAY(BDLY), .PERIOD_MAX(PMAX), .PERIOD_SPLIT(PSPLIT),
              .PERIOD_MIN(PMIN)) twg_gen_inst (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .write_forward_gate_b(write_forward_gate_b),
        .write_track_zero(write_track_zero), .write_track_one(write_track_one),
        .write_tracks_hi(write_tracks_hi),
        .write_parity_track(write_parity_track),
        .write_strobe(write_strobe), .write_reset_pulse(write_reset_pulse));

    twg_partner twg_partner_inst (
        .clk(clk),
        .tracks({write_tracks_hi, write_track_one, write_track_zero}),
        .parity(write_parity_track), .strobe(write_strobe),
        .reset_pulse(write_reset_pulse), .gate_b(write_forward_gate_b),
        .motion_cmd(motion_cmd));

    // ------------------------------------------------------------------
    // shared tasks and expectations
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time,
                     seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    function automatic logic [8:0] expect_char(input int idx, input logic odd,
                                               input logic seven);
        logic [7:0] ch;
        ch = seven ? (pat[idx] & 8'hFC) : pat[idx];
        return {^ch ^ odd, ch};
    endfunction : expect_char

    task automatic run_cont(input logic [3:0] ctrl, input logic [31:0] period,
                            input int n, input int ivl);
        int i;
        int idx;
        reg_write(REG_CTRL, {28'h0000000, ctrl});
        reg_write(REG_PERIOD, period);
        repeat (2 * PMAX) @(posedge clk);
        twg_partner_inst.clear_log();
        repeat (n * ivl + 100) @(posedge clk);
        check(twg_partner_inst.stb_interval, ivl);
        check(twg_partner_inst.stb_width, STB_WID_CYC);
        check(twg_partner_inst.unstable, 0);
        check(twg_partner_inst.rst_cnt, 0);
        check(twg_partner_inst.stb_cnt >= n, 1);
        idx = twg_partner_inst.cap[0][7:4];
        for (i = 0; i < twg_partner_inst.cap.size(); i++) begin
            exp_char = expect_char((idx + i) % 10, ctrl[CTRL_ODD],
                                   ctrl[CTRL_SEVEN]);
            check(twg_partner_inst.cap[i], exp_char);
        end
    endtask : run_cont

    // ------------------------------------------------------------------
    // cycle limit
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        int i;
        void'($urandom(32'h314F));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        check(write_strobe, 1'b0);
        check({write_tracks_hi, write_track_one, write_track_zero}, 8'h00);
        reg_read(REG_CTRL, rd);
        check(rd, 32'h00000000);
        reg_read(8'h0C, rd);
        check(rd, 32'h00000000);
        // upper nibble is the index, so rotation order stays readable
        for (i = 0; i < 10; i++) begin
            pat[i] = {4'(i), 4'($urandom)};
            reg_write(8'(REG_PAT0 + 4 * i), {24'h000000, pat[i]});
        end
        reg_read(8'(REG_PAT0 + 12), rd);
        check(rd, {24'h000000, pat[3]});
        reg_read(8'h54, rd);
        check(rd, 32'h00000000);
        // low range, even, nine-track; over-long period clamps
        run_cont(4'h0, 32'd5000, 4, PMAX);
        // high range, odd, seven-track; short period clamps, wraps past nine
        run_cont(4'hE, 32'(100 + $urandom % 800), 12, PMIN);
        // burst: nothing written while the gate is off
        // switch modes between strobes so none is cut short
        @(negedge write_strobe);
        reg_write(REG_CTRL, 32'h00000009);
        repeat (2 * PMAX) @(posedge clk);
        twg_partner_inst.clear_log();
        repeat (3000) @(posedge clk);
        check(twg_partner_inst.stb_cnt, 0);
        reg_read(REG_STATUS, rd);
        check(rd, 32'h00000109);
        twg_partner_inst.block_cycle(8500, 6000, end_cnt);
        check(twg_partner_inst.first_t - twg_partner_inst.gate_fall_t >= BDLY,
              1);
        check(twg_partner_inst.first_t - twg_partner_inst.gate_fall_t <=
              BDLY + PMIN + 600, 1);
        check(twg_partner_inst.stb_cnt, end_cnt);
        check(twg_partner_inst.stb_cnt >= 7, 1);
        check(twg_partner_inst.rst_cnt, 1);
        check(twg_partner_inst.rst_rise_t - twg_partner_inst.gate_rise_t >=
              3 * PMIN, 1);
        check(twg_partner_inst.rst_rise_t - twg_partner_inst.gate_rise_t <=
              4 * PMIN + 10, 1);
        check(twg_partner_inst.rst_width, STB_WID_CYC);
        check(twg_partner_inst.rst_rise_t < twg_partner_inst.lrc_t, 1);
        exp_lrc = 9'h000;
        for (i = 0; i < twg_partner_inst.cap.size(); i++) begin
            exp_char = expect_char(i % 10, 1'b0, 1'b0);
            check(twg_partner_inst.cap[i], exp_char);
            exp_lrc ^= exp_char;
        end
        check(twg_partner_inst.lrc, exp_lrc);
        check(motion_cmd, 1'b0);
        close_out();
    end
endmodule : twg_gen_bench

`default_nettype wire
